// >>> hw/hpsp_regs.vh
// constants for the hub port strap and power pin block
`ifndef HPSP_REGS_VH
`define HPSP_REGS_VH
`define HPSP_NPORTS         7
`define HPSP_NPORTS_W       3
`define HPSP_ENH_LO         4
`define HPSP_GANG_PORT      3
`define HPSP_STRAP_CYCLES   4'h3
`define HPSP_RST_OFF        7'h00
`define HPSP_RST_SWAP       7'h00
`define HPSP_RST_GANG       1'b0
`endif

// >>> hw/hpsp_sync.v
// two flip-flop synchroniser, parameterised width
`timescale 1ns/1ps
module hpsp_sync #(
    parameter W = 1
) (
    input  wire         i_clk,
    input  wire         i_arst_n,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= i_d;
            sync_r <= meta_r;
        end
    end
    assign o_q = sync_r;
endmodule // hpsp_sync

// >>> hw/hpsp_top.v
// strap sampling, led polarity, power enable and connect logic
`timescale 1ns/1ps
`include "hpsp_regs.vh"
//////////////////////////////////////////////////////////////////////////////
// How it works
// - names ending _N or _low are asserted low; all others high except the led outputs
// - upstream power detect, synchronised, gates the upstream pull-up enable
// - each strap sampled only when its enable input allows; else default
// - port-off straps sampled at reset release; high marks port disabled
// - port power enables driven active high
// - pair polarity straps sampled at reset release per port
// - swap 0 keeps polarity, primary led high; 1 swaps, led low
// - primary leds 1-7 driven only when led support enabled
// - enhanced leds 4-7 active low when led support enabled
// - gang strap sampled at release selects ganged or per-port power/sense
// - gang 0 individual, port-3 led high; 1 ganged, led low
// - active-low overcurrent sense input reports fault when low
module hpsp_top #(
    parameter NPORTS = `HPSP_NPORTS
) (
    input  wire              I_CLK,
    input  wire              I_ARST_N,
    input  wire              I_UPSTREAM_POWER_DETECT,
    input  wire [NPORTS-1:0] I_PORT_OFF_STRAP_PLUS,
    input  wire [NPORTS-1:0] I_PORT_OFF_STRAP_MINUS,
    input  wire [NPORTS-1:0] I_PAIR_POLARITY_STRAP,
    input  wire              I_GANG_STRAP,
    input  wire              I_OFF_STRAP_EN,
    input  wire              I_SWAP_STRAP_EN,
    input  wire              I_GANG_STRAP_EN,
    input  wire              I_LED_EN,
    input  wire [NPORTS-1:0] I_PORT_POWER_REQ,
    input  wire [NPORTS-1:0] I_PRIMARY_LED_ON,
    input  wire [NPORTS-1:0] I_ENHANCED_LED_ON,
    input  wire [NPORTS-1:0] I_OVERCURRENT_SENSE_LOW_N,
    output reg               O_UPSTREAM_PULLUP_EN,
    output reg               O_STRAP_DONE,
    output reg  [NPORTS-1:0] O_PORT_POWER_ENABLE,
    output reg  [NPORTS-1:0] O_PORT_DISABLED,
    output reg  [NPORTS-1:0] O_PAIR_SWAPPED,
    output reg               O_GANGED,
    output reg  [NPORTS-1:0] O_OVERCURRENT,
    output reg  [NPORTS-1:0] O_PRIMARY_PORT_LED,
    output reg  [NPORTS-1:0] O_PRIMARY_PORT_LED_OE_N,
    output reg  [NPORTS-1:0] O_ENHANCED_PORT_LED,
    output reg  [NPORTS-1:0] O_ENHANCED_PORT_LED_OE_N
);
    localparam ST_SAMPLE = 2'b01;
    localparam ST_RUN    = 2'b10;
    //////////////////////////////////////////////////////////////////////////
    // synchronisers
    wire [3*NPORTS+1:0] raw_in;
    wire [3*NPORTS+1:0] syn;
    wire [NPORTS-1:0]   ocs_n_s;
    assign raw_in = {I_UPSTREAM_POWER_DETECT, I_GANG_STRAP, I_PAIR_POLARITY_STRAP,
                     I_PORT_OFF_STRAP_PLUS | I_PORT_OFF_STRAP_MINUS, I_OVERCURRENT_SENSE_LOW_N};
    hpsp_sync #(.W(3*NPORTS+2)) u_sync (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_d      (raw_in),
        .o_q      (syn)
    );
    wire              vbus_s = syn[3*NPORTS+1];
    wire              gang_s = syn[3*NPORTS];
    wire [NPORTS-1:0] swap_s = syn[3*NPORTS-1:2*NPORTS];
    wire [NPORTS-1:0] off_s  = syn[2*NPORTS-1:NPORTS];
    assign ocs_n_s = syn[NPORTS-1:0];
    //////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    reg [1:0]        state_r;
    reg [3:0]        cnt_r;
    reg [NPORTS-1:0] off_r;
    reg [NPORTS-1:0] swap_r;
    reg              gang_r;
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_r <= ST_SAMPLE;
            cnt_r   <= 4'h0;
            off_r   <= `HPSP_RST_OFF;
            swap_r  <= `HPSP_RST_SWAP;
            gang_r  <= `HPSP_RST_GANG;
        end else begin
            case (state_r)
                ST_SAMPLE: begin
                    if (cnt_r == `HPSP_STRAP_CYCLES) begin
                        state_r <= ST_RUN;
                        off_r   <= I_OFF_STRAP_EN ? off_s : {NPORTS{1'b0}};
                        swap_r  <= I_SWAP_STRAP_EN ? swap_s : {NPORTS{1'b0}};
                        gang_r  <= I_GANG_STRAP_EN ? gang_s : 1'b0;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_SAMPLE;
                end
            endcase
        end
    end
    wire done = (state_r == ST_RUN);
    //////////////////////////////////////////////////////////////////////////
    // outputs
    integer k;
    reg [NPORTS-1:0] oc_nxt;
    reg [NPORTS-1:0] pwr_nxt;
    reg [NPORTS-1:0] la_nxt;
    reg [NPORTS-1:0] lb_nxt;
    always @* begin
        oc_nxt  = ~ocs_n_s;
        if (gang_r && (|oc_nxt)) begin
            oc_nxt = {NPORTS{1'b1}};
        end
        pwr_nxt = gang_r ? {NPORTS{|(I_PORT_POWER_REQ & ~off_r)}} : I_PORT_POWER_REQ;
        pwr_nxt = pwr_nxt & ~off_r & ~oc_nxt;
        for (k = 0; k < NPORTS; k = k + 1) begin
            la_nxt[k] = I_PRIMARY_LED_ON[k] ^ swap_r[k];
            if (k == `HPSP_GANG_PORT - 1) begin
                lb_nxt[k] = I_ENHANCED_LED_ON[k] ^ gang_r;
            end else if (k >= `HPSP_ENH_LO - 1) begin
                lb_nxt[k] = ~I_ENHANCED_LED_ON[k];
            end else begin
                lb_nxt[k] = 1'b1;
            end
        end
    end
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_UPSTREAM_PULLUP_EN     <= 1'b0;
            O_STRAP_DONE             <= 1'b0;
            O_PORT_POWER_ENABLE      <= {NPORTS{1'b0}};
            O_PORT_DISABLED          <= {NPORTS{1'b0}};
            O_PAIR_SWAPPED           <= {NPORTS{1'b0}};
            O_GANGED                 <= 1'b0;
            O_OVERCURRENT            <= {NPORTS{1'b0}};
            O_PRIMARY_PORT_LED       <= {NPORTS{1'b1}};
            O_PRIMARY_PORT_LED_OE_N  <= {NPORTS{1'b1}};
            O_ENHANCED_PORT_LED      <= {NPORTS{1'b1}};
            O_ENHANCED_PORT_LED_OE_N <= {NPORTS{1'b1}};
        end else begin
            O_UPSTREAM_PULLUP_EN     <= done & vbus_s;
            O_STRAP_DONE             <= done;
            O_PORT_POWER_ENABLE      <= done ? pwr_nxt : {NPORTS{1'b0}};
            O_PORT_DISABLED          <= off_r;
            O_PAIR_SWAPPED           <= swap_r;
            O_GANGED                 <= gang_r;
            O_OVERCURRENT            <= done ? oc_nxt : {NPORTS{1'b0}};
            O_PRIMARY_PORT_LED       <= la_nxt;
            O_PRIMARY_PORT_LED_OE_N  <= {NPORTS{~(done & I_LED_EN)}};
            O_ENHANCED_PORT_LED      <= lb_nxt;
            O_ENHANCED_PORT_LED_OE_N <= {NPORTS{~(done & I_LED_EN)}};
        end
    end
endmodule // hpsp_top

// >>> bench/hpsp_pins.sv
// pull resistors, led pins and current monitors beside the block
`timescale 1ns/1ps
module hpsp_pins (
    input  wire [6:0] i_pull, i_led, i_oe_n, i_fault,
    output wire [6:0] o_pin, o_oc_n
);
    assign o_pin = (i_pull & i_oe_n) | (i_led & ~i_oe_n);
    assign o_oc_n = ~i_fault;
endmodule // hpsp_pins

// >>> bench/hpsp_sva.sv
// checker for strap latching, led polarity and power gating
`timescale 1ns/1ps
module hpsp_sva #(parameter NPORTS = 7) (
    input wire I_CLK, I_ARST_N, I_UPSTREAM_POWER_DETECT, I_LED_EN, O_UPSTREAM_PULLUP_EN,
    input wire O_STRAP_DONE, O_GANGED,
    input wire [NPORTS-1:0] I_PRIMARY_LED_ON, I_ENHANCED_LED_ON, I_OVERCURRENT_SENSE_LOW_N,
    input wire [NPORTS-1:0] O_PORT_POWER_ENABLE, O_PORT_DISABLED, O_PAIR_SWAPPED, O_OVERCURRENT,
    input wire [NPORTS-1:0] O_PRIMARY_PORT_LED, O_PRIMARY_PORT_LED_OE_N, O_ENHANCED_PORT_LED
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    property p_hold; O_STRAP_DONE |=> O_STRAP_DONE && $stable(O_PORT_DISABLED)
        && $stable(O_PAIR_SWAPPED) && $stable(O_GANGED); endproperty
    a_hold: assert property (p_hold) else $error("strap lost");
    property p_idle; !O_STRAP_DONE |-> !O_UPSTREAM_PULLUP_EN && !O_PORT_POWER_ENABLE; endproperty
    a_idle: assert property (p_idle) else $error("early power");
    property p_pull; $past(O_STRAP_DONE, 3) |->
        O_UPSTREAM_PULLUP_EN == $past(I_UPSTREAM_POWER_DETECT, 3); endproperty
    a_pull: assert property (p_pull) else $error("pullup");
    property p_off; !(O_PORT_POWER_ENABLE & O_PORT_DISABLED); endproperty
    a_off: assert property (p_off) else $error("off port powered");
    property p_oc; $past(O_STRAP_DONE, 3) |-> O_OVERCURRENT == (O_GANGED ?
        {NPORTS{~&$past(I_OVERCURRENT_SENSE_LOW_N, 3)}} : ~$past(I_OVERCURRENT_SENSE_LOW_N, 3));
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent");
    property p_loe; $past(O_STRAP_DONE) |-> O_PRIMARY_PORT_LED_OE_N == {NPORTS{!$past(I_LED_EN)}};
    endproperty
    a_loe: assert property (p_loe) else $error("led drive");
    property p_pled; $past(O_STRAP_DONE) |->
        O_PRIMARY_PORT_LED == ($past(I_PRIMARY_LED_ON) ^ O_PAIR_SWAPPED); endproperty
    a_pled: assert property (p_pled) else $error("primary led");
    property p_eled; $past(O_STRAP_DONE) |->
        O_ENHANCED_PORT_LED[6:3] == ~$past(I_ENHANCED_LED_ON[6:3]); endproperty
    a_eled: assert property (p_eled) else $error("enhanced led");
    c_gang: cover property (O_STRAP_DONE && O_GANGED);
    c_swap: cover property (O_STRAP_DONE && |O_PAIR_SWAPPED);
    c_pull: cover property ($rose(O_UPSTREAM_PULLUP_EN));
endmodule // hpsp_sva
bind hpsp_top hpsp_sva #(.NPORTS(NPORTS)) hpsp_sva_i (.*);

// >>> bench/hpsp_top_tb_top.sv
// randomised bench for the strap and power pin block
`timescale 1ns/1ps
module hpsp_top_tb_top;
    logic       c = 0, r = 0, d = 0, g = 0, le = 0, xg;
    logic [2:0] en = 0;
    logic [6:0] p = 0, m = 0, s = 0, q = 0, a = 0, b = 0, f = 0, xd, xs, xo;
    wire  [6:0] ps, on, al, ao, bl, bo, w, ds, sw, oc;
    wire        pu, dn, gg;
    integer     seed = 75, bad_count = 0, tests_run = 0, i, k;
    always #50 c = ~c;
    hpsp_pins hpsp_pins_i (.i_pull(s), .i_led(al), .i_oe_n(ao), .i_fault(f), .o_pin(ps), .o_oc_n(on));
    hpsp_top hpsp_top_i (.I_CLK(c), .I_ARST_N(r), .I_UPSTREAM_POWER_DETECT(d),
        .I_PORT_OFF_STRAP_PLUS(p), .I_PORT_OFF_STRAP_MINUS(m), .I_PAIR_POLARITY_STRAP(ps),
        .I_GANG_STRAP(bo[2] ? g : bl[2]), .I_OFF_STRAP_EN(en[0]), .I_SWAP_STRAP_EN(en[1]),
        .I_GANG_STRAP_EN(en[2]), .I_LED_EN(le), .I_PORT_POWER_REQ(q), .I_PRIMARY_LED_ON(a),
        .I_ENHANCED_LED_ON(b), .I_OVERCURRENT_SENSE_LOW_N(on), .O_UPSTREAM_PULLUP_EN(pu),
        .O_STRAP_DONE(dn), .O_PORT_POWER_ENABLE(w), .O_PORT_DISABLED(ds), .O_PAIR_SWAPPED(sw),
        .O_GANGED(gg), .O_OVERCURRENT(oc), .O_PRIMARY_PORT_LED(al), .O_PRIMARY_PORT_LED_OE_N(ao),
        .O_ENHANCED_PORT_LED(bl), .O_ENHANCED_PORT_LED_OE_N(bo));
    task chk(input [6:0] e, v, input string n);
        tests_run++;
        if (e !== v) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, v);
        end
    endtask
    task complete_run;
        $display("mismatches %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function [6:0] pw(input [6:0] rq, x, o, input gm);
        pw = (gm ? {7{|(rq & ~x)}} & ~x : rq & ~x) & ~o;
    endfunction
    initial begin
        for (i = 0; i < 8; i++) begin
            @(posedge c);
            r <= 0;
            en <= (i < 2) ? 3'(i * 7) : 3'($random(seed));
            {p, m, s, g, le} <= 23'($random(seed));
            repeat (3) @(posedge c);
            r <= 1;
            for (k = 0; k < 20 && dn !== 1; k++) @(negedge c);
            if (k == 20) begin bad_count++; complete_run; end
            xd = en[0] ? p | m : 7'h00;
            xs = en[1] ? s : 7'h00;
            xg = en[2] & g;
            chk(xd, ds, "disabled");
            chk(xs, sw, "swapped");
            chk({6'h00, xg}, {6'h00, gg}, "ganged");
            for (k = 0; k < 6; k++) begin
                @(posedge c);
                {q, a, b, d} <= 22'($random(seed));
                f <= k > 3 ? 7'($random(seed)) : 7'h00;
                {p, m, s, g} <= 22'($random(seed));
                repeat (5) @(negedge c);
                xo = xg ? {7{|f}} : f;
                chk(xo, oc, "overcurrent");
                chk(pw(q, xd, xo, xg), w, "power");
                chk({6'h00, d}, {6'h00, pu}, "pullup");
                chk(xd, ds, "held");
                chk({7{~le}}, ao, "led drive");
                chk({7{~le}}, bo, "enhanced drive");
                chk(a ^ xs, al, "primary led");
                chk({~b[6:3], b[2] ^ xg, 2'h3}, bl, "enhanced led");
            end
        end
        complete_run;
    end
endmodule // hpsp_top_tb_top
